// ===== verilog/mrb_ctrl.sv
// mirror reset block control: strobed line driver, command port, row load
//
// Contract
// - full-duplex byte-wide serial command port, one port
// - port has select, clock, data in/out, irq
// - count select picks one, two, four, all
// - level select picks bias, offset or pulse
// - four-bit address names the acted-on group
// - strobe edge floats lines, then latches level
// - lines hold last latched level until changed
// - pulse with release lets mirrors relax first; no release level here, a pulse strobe floats then latches like bias or offset
// - sixteen blocks of fifty rows, mode picks blocks
// - single mode pulses any one block
// - dual mode pairs blocks 0-1 through 14-15
// - quad mode groups 0-3 through 12-15
// - replicate mode writes each line to four rows
// - even block tail also writes next block head
// - lines switch among three levels forming waveforms
// - status output shows reset in progress
`timescale 1ns/1ps
`default_nettype none

module mrb_ctrl
  import mrb_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // strobed driver control pins
  input  wire logic        i_strobe,
  input  wire logic [1:0]  i_count_sel,
  input  wire logic [1:0]  i_level_sel,
  input  wire logic [3:0]  i_group_addr,
  output logic [31:0]      o_mirror_pulse_lines,
  output logic [15:0]      o_mirror_pulse_hiz,
  output logic             o_reset_active,
  // serial command port pins
  input  wire logic        i_command_port_select_n,
  input  wire logic        i_command_port_clock,
  input  wire logic        i_command_port_data_in,
  output logic             o_command_port_data_out,
  output logic             o_command_port_data_out_oe,
  output logic             o_command_port_irq,
  output logic [7:0]       o_cmd_byte,
  output logic             o_cmd_valid,
  // row load path from user logic on this clock
  input  wire logic        i_row_replicate_load,
  input  wire logic        i_line_valid,
  input  wire logic [9:0]  i_line_index,
  output logic             o_row_wr_valid,
  output logic [9:0]       o_row_wr_first,
  output logic [9:0]       o_row_wr_last,
  output logic [15:0]      o_row_wr_blocks
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // lines acted on by one strobe, by count select and address
  function automatic logic [15:0] group_mask(input logic [1:0] cnt,
                                             input logic [3:0] addr);
    logic [15:0] m;
    m = 16'h0000;
    case (cnt)
      CNT_SINGLE: m = 16'h0001 << addr;
      CNT_DUAL:   m = 16'h0003 << {addr[3:1], 1'b0};
      CNT_QUAD:   m = 16'h000F << {addr[3:2], 2'b00};
      CNT_GLOBAL: m = 16'hFFFF;
      default:    m = 16'h0000;
    endcase
    return m;
  endfunction

  // block holding a row
  function automatic logic [3:0] row_block(input logic [9:0] row);
    logic [9:0] q;
    q = row / 10'(ROWS_PER_BLOCK);
    return q[3:0];
  endfunction

  // mask of blocks spanned by a row range
  function automatic logic [15:0] span_mask(input logic [9:0] first,
                                            input logic [9:0] last);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = 16'hFFFF << row_block(first);
    hi = 16'hFFFF >> (4'hF - row_block(last));
    return lo & hi;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers: three stages, agreement of last two counts
  // ---------------------------------------------------------------
  localparam int NSYNC = 12;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] sync3_reg;
  logic [NSYNC-1:0] pin_reg;

  assign pin_raw = {i_command_port_data_in, i_command_port_clock,
                    i_command_port_select_n, i_strobe, i_group_addr,
                    i_level_sel, i_count_sel};

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_reg <= 12'h200;
      sync2_reg <= 12'h200;
      sync3_reg <= 12'h200;
      pin_reg   <= 12'h200;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < NSYNC; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pin_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  logic [1:0] cnt_sel;
  logic [1:0] lvl_sel;
  logic [3:0] grp_addr;
  logic       strobe_s;
  logic       sel_n_s;
  logic       sclk_s;
  logic       sdi_s;

  assign cnt_sel  = pin_reg[1:0];
  assign lvl_sel  = pin_reg[3:2];
  assign grp_addr = pin_reg[7:4];
  assign strobe_s = pin_reg[8];
  assign sel_n_s  = pin_reg[9];
  assign sclk_s   = pin_reg[10];
  assign sdi_s    = pin_reg[11];

  logic strobe_d_reg;
  logic sel_n_d_reg;
  logic sclk_d_reg;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      strobe_d_reg <= 1'b0;
      sel_n_d_reg  <= 1'b1;
      sclk_d_reg   <= 1'b0;
    end else begin
      strobe_d_reg <= strobe_s;
      sel_n_d_reg  <= sel_n_s;
      sclk_d_reg   <= sclk_s;
    end
  end

  logic strobe_rise;
  assign strobe_rise = strobe_s & ~strobe_d_reg;

  // ---------------------------------------------------------------
  // strobe sequencer
  // ---------------------------------------------------------------
  mrb_state_e  state_reg;
  logic [3:0]  bbm_cnt_reg;
  logic [15:0] act_mask_reg;
  logic [1:0]  act_level_reg;

  // strobes arriving mid-sequence are dropped, the float must finish
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg     <= ST_IDLE;
      bbm_cnt_reg   <= 4'h0;
      act_mask_reg  <= 16'h0000;
      act_level_reg <= RST_LEVEL;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (strobe_rise && lvl_sel != LVL_NONE) begin
            act_mask_reg  <= group_mask(cnt_sel, grp_addr);
            act_level_reg <= lvl_sel;
            bbm_cnt_reg   <= BBM_COUNT;
            state_reg     <= ST_FLOAT;
          end
        end
        ST_FLOAT: begin
          if (bbm_cnt_reg == 4'h1) begin
            state_reg <= ST_LATCH;
          end
          bbm_cnt_reg <= bbm_cnt_reg - 4'h1;
        end
        ST_LATCH: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // line levels: untouched lines keep their level
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mirror_pulse_lines <= {NUM_BLOCKS{RST_LEVEL}};
      o_mirror_pulse_hiz   <= RST_HIZ;
    end else begin
      if (state_reg == ST_IDLE && strobe_rise && lvl_sel != LVL_NONE) begin
        o_mirror_pulse_hiz <= o_mirror_pulse_hiz
                              | group_mask(cnt_sel, grp_addr);
      end else if (state_reg == ST_LATCH) begin
        for (int i = 0; i < NUM_BLOCKS; i++) begin
          if (act_mask_reg[i]) begin
            o_mirror_pulse_lines[2*i +: 2] <= act_level_reg;
          end
        end
        o_mirror_pulse_hiz <= o_mirror_pulse_hiz & ~act_mask_reg;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reset_active <= 1'b0;
    end else begin
      o_reset_active <= (state_reg == ST_IDLE)
                        ? (strobe_rise && lvl_sel != LVL_NONE)
                        : (state_reg == ST_FLOAT);
    end
  end

  // ---------------------------------------------------------------
  // serial command port, mode 0: sample on rise, shift on fall
  // ---------------------------------------------------------------
  logic       port_active;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       sel_fall;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] tx_shift_reg;
  logic       byte_done;

  assign port_active = ~sel_n_s;
  assign sclk_rise   = port_active & sclk_s & ~sclk_d_reg;
  assign sclk_fall   = port_active & ~sclk_s & sclk_d_reg;
  assign sel_fall    = ~sel_n_s & sel_n_d_reg;
  assign byte_done   = sclk_rise && bit_cnt_reg == 3'h7;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_reg  <= 3'h0;
      rx_shift_reg <= RST_BYTE;
      o_cmd_byte   <= RST_BYTE;
      o_cmd_valid  <= 1'b0;
    end else begin
      o_cmd_valid <= byte_done;
      if (!port_active) begin
        bit_cnt_reg <= 3'h0;
      end else if (sclk_rise) begin
        rx_shift_reg <= {rx_shift_reg[6:0], sdi_s};
        bit_cnt_reg  <= bit_cnt_reg + 3'h1;
        if (byte_done) begin
          o_cmd_byte <= {rx_shift_reg[6:0], sdi_s};
        end
      end
    end
  end

  // reply stream carries the sequencer state, reloaded every byte
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_shift_reg               <= RST_BYTE;
      o_command_port_data_out    <= 1'b0;
      o_command_port_data_out_oe <= 1'b0;
    end else begin
      o_command_port_data_out_oe <= port_active;
      if (sel_fall || byte_done) begin
        tx_shift_reg <= {act_level_reg, state_reg, 2'b00, o_reset_active};
      end else if (sclk_fall) begin
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
      o_command_port_data_out <= tx_shift_reg[7];
    end
  end

  // irq: set on each byte, cleared on deselect; set wins
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_command_port_irq <= 1'b0;
    end else if (byte_done) begin
      o_command_port_irq <= 1'b1;
    end else if (!port_active) begin
      o_command_port_irq <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // row write generation
  // ---------------------------------------------------------------
  logic [11:0] rep_first;
  logic [11:0] rep_last;
  logic [9:0]  wr_first;
  logic [9:0]  wr_last;
  logic        line_ok;

  // lines past the array end are dropped, not wrapped
  always_comb begin
    rep_first = {i_line_index, 2'b00};
    rep_last  = rep_first + 12'(REPLICATE_ROWS - 1);
    if (i_row_replicate_load) begin
      wr_first = rep_first[9:0];
      wr_last  = rep_last[9:0];
      line_ok  = rep_last < 12'(NUM_ROWS);
    end else begin
      wr_first = i_line_index;
      wr_last  = i_line_index;
      line_ok  = i_line_index < 10'(NUM_ROWS);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_row_wr_valid  <= 1'b0;
      o_row_wr_first  <= 10'h000;
      o_row_wr_last   <= 10'h000;
      o_row_wr_blocks <= 16'h0000;
    end else begin
      o_row_wr_valid <= i_line_valid && line_ok;
      if (i_line_valid && line_ok) begin
        o_row_wr_first  <= wr_first;
        o_row_wr_last   <= wr_last;
        o_row_wr_blocks <= span_mask(wr_first, wr_last);
      end
    end
  end

endmodule

`default_nettype wire

// ===== verilog/mrb_pkg.sv
// shared constants for the mirror reset block control
package mrb_pkg;

  localparam int          NUM_BLOCKS     = 16;
  localparam int          ROWS_PER_BLOCK = 50;
  localparam int          NUM_ROWS       = 800;
  localparam int          REPLICATE_ROWS = 4;

  // output-count select codes
  localparam logic [1:0]  CNT_SINGLE     = 2'h0;
  localparam logic [1:0]  CNT_DUAL       = 2'h1;
  localparam logic [1:0]  CNT_QUAD       = 2'h2;
  localparam logic [1:0]  CNT_GLOBAL     = 2'h3;

  // level select codes; the fourth code leaves the lines alone
  localparam logic [1:0]  LVL_BIAS       = 2'h0;
  localparam logic [1:0]  LVL_OFFSET     = 2'h1;
  localparam logic [1:0]  LVL_PULSE      = 2'h2;
  localparam logic [1:0]  LVL_NONE       = 2'h3;

  // reset values
  localparam logic [1:0]  RST_LEVEL      = 2'h0;
  localparam logic [15:0] RST_HIZ        = 16'h0000;
  localparam logic [7:0]  RST_BYTE       = 8'h00;

  // timing
  localparam int          CLK_PERIOD_PS  = 4000;
  localparam int          BBM_TIME_NS    = 20;
  localparam int          BBM_CYCLES     =
    (BBM_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0]  BBM_COUNT      = 4'(BBM_CYCLES);

  // one-hot sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FLOAT = 3'b010,
    ST_LATCH = 3'b100
  } mrb_state_e;

endpackage

// ===== bench/mrb_ctrl_assertions.sv
// port checks for the mirror reset block control
`timescale 1ns/1ps
`default_nettype none
module mrb_ctrl_chk (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_command_port_select_n,
  input wire logic        i_row_replicate_load,
  input wire logic        i_line_valid,
  input wire logic [9:0]  i_line_index,
  input wire logic [31:0] o_mirror_pulse_lines,
  input wire logic [15:0] o_mirror_pulse_hiz,
  input wire logic        o_reset_active,
  input wire logic        o_command_port_data_out_oe,
  input wire logic        o_command_port_irq,
  input wire logic        o_cmd_valid,
  input wire logic        o_row_wr_valid,
  input wire logic [9:0]  o_row_wr_first,
  input wire logic [9:0]  o_row_wr_last
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_float; o_reset_active [*6]; endsequence
  sequence s_latch;
    !o_reset_active && o_mirror_pulse_hiz == 16'h0000;
  endsequence
  property p_bbm; $rose(o_reset_active) |-> s_float ##1 s_latch; endproperty
  a_bbm: assert property (p_bbm) else $error("float phase length");
  property p_act;
    o_reset_active == (o_mirror_pulse_hiz != 16'h0000);
  endproperty
  a_act: assert property (p_act) else $error("busy vs float");
  property p_hold;
    $changed(o_mirror_pulse_lines) |-> $fell(o_reset_active);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved");
  property p_irq; o_cmd_valid |-> ##[0:1] o_command_port_irq; endproperty
  a_irq: assert property (p_irq) else $error("no irq");
  property p_pulse; o_cmd_valid |=> !o_cmd_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("byte pulse long");
  property p_oe;
    $rose(i_command_port_select_n) |-> ##[1:8] !o_command_port_data_out_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("oe after deselect");
  property p_row; i_line_valid && i_line_index < 10'd200 |=> o_row_wr_valid;
  endproperty
  a_row: assert property (p_row) else $error("row lost");
  property p_rep; o_row_wr_valid && $past(i_row_replicate_load) |->
    o_row_wr_last == o_row_wr_first + 10'd3 && o_row_wr_first[1:0] == 2'h0;
  endproperty
  a_rep: assert property (p_rep) else $error("replica range");
endmodule
bind mrb_ctrl mrb_ctrl_chk i_mrb_ctrl_chk (.i_core_clk, .i_rst,
  .i_command_port_select_n, .i_row_replicate_load, .i_line_valid,
  .i_line_index, .o_mirror_pulse_lines, .o_mirror_pulse_hiz, .o_reset_active,
  .o_command_port_data_out_oe, .o_command_port_irq, .o_cmd_valid,
  .o_row_wr_valid, .o_row_wr_first, .o_row_wr_last);
`default_nettype wire

// ===== bench/mrb_host_model.sv
// controller model: strobed selects and serial command frames
`timescale 1ns/1ps
`default_nettype none
module mrb_host_model (
  input  wire logic  i_core_clk,
  output logic       o_strobe,    // strobe of the single control set
  output logic [1:0] o_count_sel,
  output logic [1:0] o_level_sel,
  output logic [3:0] o_group_addr,
  output logic       o_select_n,
  output logic       o_sclk,
  output logic       o_sdata
);
  initial begin
    {o_strobe, o_count_sel, o_level_sel, o_group_addr} = 9'h000;
    {o_select_n, o_sclk, o_sdata} = 3'b100;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  // selects settle 8 cycles around the strobe edge
  task automatic pulse(input logic [1:0] c, l, input logic [3:0] a);
    tk(1);
    {o_count_sel, o_level_sel, o_group_addr} = {c, l, a};
    tk(8);
    o_strobe = 1'b1;
    tk(8);
    o_strobe = 1'b0;
    tk(8);
  endtask
  // clock stands low outside frames, msb first
  task automatic send(input logic [7:0] b, input int n);
    int k;
    tk(1);
    o_select_n = 1'b0;
    for (k = 7; k > 7 - n; k--) begin
      o_sdata = b[k];
      tk(8);
      o_sclk = 1'b1;
      tk(8);
      o_sclk = 1'b0;
    end
    tk(8);
    o_select_n = 1'b1;
    // released line: no pull, so show the inverse
    o_sdata = ~o_sdata;
  endtask
endmodule
`default_nettype wire

// ===== bench/mrb_ctrl_test.sv
// self-checking bench for the mirror reset block control
`timescale 1ns/1ps
`default_nettype none
module mrb_ctrl_test
  import mrb_pkg::*;
;
  logic i_core_clk, i_rst, i_strobe, i_command_port_select_n;
  logic i_command_port_clock, i_command_port_data_in, i_line_valid;
  logic i_row_replicate_load, o_reset_active, o_command_port_data_out;
  logic o_command_port_data_out_oe, o_command_port_irq, o_cmd_valid;
  logic o_row_wr_valid;
  logic [1:0] i_count_sel, i_level_sel, c, l;
  logic [3:0] i_group_addr, a;
  logic [9:0] i_line_index, o_row_wr_first, o_row_wr_last;
  logic [15:0] o_mirror_pulse_hiz, o_row_wr_blocks, m;
  logic [31:0] o_mirror_pulse_lines, exp_lines;
  logic [7:0] o_cmd_byte;
  int miscompares = 0;
  int checks = 0;
  int i, j, n;
  // waveform steps for the one array type fitted
  localparam logic [7:0] TBL [6] = '{{CNT_SINGLE, LVL_PULSE, 4'h5},
    {CNT_DUAL, LVL_OFFSET, 4'h9}, {CNT_QUAD, LVL_PULSE, 4'hE},
    {CNT_GLOBAL, LVL_OFFSET, 4'h0}, {CNT_SINGLE, LVL_BIAS, 4'h0},
    {CNT_QUAD, LVL_NONE, 4'h3}};
  mrb_ctrl i_mrb_ctrl (.i_core_clk, .i_rst, .i_strobe, .i_count_sel,
    .i_level_sel, .i_group_addr, .o_mirror_pulse_lines, .o_mirror_pulse_hiz,
    .o_reset_active, .i_command_port_select_n, .i_command_port_clock,
    .i_command_port_data_in, .o_command_port_data_out,
    .o_command_port_data_out_oe, .o_command_port_irq, .o_cmd_byte,
    .o_cmd_valid, .i_row_replicate_load, .i_line_valid, .i_line_index,
    .o_row_wr_valid, .o_row_wr_first, .o_row_wr_last, .o_row_wr_blocks);
  mrb_host_model i_mrb_host_model (.i_core_clk, .o_strobe(i_strobe),
    .o_count_sel(i_count_sel), .o_level_sel(i_level_sel),
    .o_group_addr(i_group_addr), .o_select_n(i_command_port_select_n),
    .o_sclk(i_command_port_clock), .o_sdata(i_command_port_data_in));
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // group size follows the count select, aligned on the address
  function automatic logic [15:0] mask_of(input logic [1:0] cs,
                                          input logic [3:0] ad);
    case (cs)
      CNT_SINGLE: return 16'h0001 << ad;
      CNT_DUAL:   return 16'h0003 << {ad[3:1], 1'b0};
      CNT_QUAD:   return 16'h000F << {ad[3:2], 2'b00};
      default:    return 16'hFFFF;
    endcase
  endfunction
  task automatic do_byte(input logic [7:0] b);
    logic [7:0] rep;
    rep = 8'h00;
    fork
      i_mrb_host_model.send(b, 8);
      // reply bits are taken at each rising serial clock, msb first
      repeat (8) begin
        @(posedge i_command_port_clock);
        rep = {rep[6:0], o_command_port_data_out};
      end
      begin
        for (n = 0; n < 200 && o_cmd_valid !== 1'b1; n++) tick(1);
        chk("byte", o_cmd_byte, b);
        tick(1);
        chk("irq", o_command_port_irq, 1'b1);
        chk("oe", o_command_port_data_out_oe, 1'b1);
      end
    join
    chk("reply", rep, {LVL_BIAS, ST_IDLE, 2'b00, 1'b0});
    tick(12);
    chk("irq off", o_command_port_irq, 1'b0);
    chk("oe off", o_command_port_data_out_oe, 1'b0);
  endtask
  task automatic row(input logic r, input logic [9:0] x, f, la,
                     input logic [15:0] b, input logic v);
    i_row_replicate_load = r;
    i_line_valid = 1'b1;
    i_line_index = x;
    tick(1);
    chk("wr valid", o_row_wr_valid, v);
    if (v) begin
      chk("first", o_row_wr_first, f);
      chk("last", o_row_wr_last, la);
      chk("blocks", o_row_wr_blocks, b);
    end
  endtask
  initial begin
    #40000;
    miscompares++;
    close_out();
  end
  initial begin
    {i_rst, i_row_replicate_load, i_line_valid, i_line_index} = 13'h1000;
    exp_lines = 32'h0000_0000;
    tick(6);
    i_rst = 1'b0;
    tick(1);
    chk("rst lines", o_mirror_pulse_lines, 32'h0000_0000);
    chk("rst busy", o_reset_active, 1'b0);
    for (i = 0; i < 6; i++) begin
      {c, l, a} = TBL[i];
      m = mask_of(c, a);
      fork
        i_mrb_host_model.pulse(c, l, a);
        begin
          for (n = 0; n < 40 && o_reset_active !== 1'b1; n++) tick(1);
          chk("busy", o_reset_active, l != LVL_NONE);
          if (o_reset_active === 1'b1) begin
            chk("float", o_mirror_pulse_hiz, m);
          end
          chk("held", o_mirror_pulse_lines, exp_lines);
        end
      join
      tick(4);
      for (j = 0; j < 16; j++) begin
        if (m[j] && l != LVL_NONE) exp_lines[2*j +: 2] = l;
      end
      chk("lines", o_mirror_pulse_lines, exp_lines);
      chk("hiz", o_mirror_pulse_hiz, 16'h0000);
    end
    do_byte(8'hA5);
    i_mrb_host_model.send(8'h3C, 4);
    tick(12);
    chk("partial", o_cmd_byte, 8'hA5);
    do_byte(8'h96);
    row(1'b0, 10'd123, 10'd123, 10'd123, 16'h0004, 1'b1);
    row(1'b0, 10'd799, 10'd799, 10'd799, 16'h8000, 1'b1);
    row(1'b1, 10'd12, 10'd48, 10'd51, 16'h0003, 1'b1);
    row(1'b1, 10'd13, 10'd52, 10'd55, 16'h0002, 1'b1);
    row(1'b1, 10'd199, 10'd796, 10'd799, 16'h8000, 1'b1);
    row(1'b1, 10'd200, 10'd0, 10'd0, 16'h0000, 1'b0);
    i_line_valid = 1'b0;
    // rows are loaded, so one global pulse lands them together
    i_mrb_host_model.pulse(CNT_GLOBAL, LVL_PULSE, 4'h0);
    chk("global", o_mirror_pulse_lines, {NUM_BLOCKS{LVL_PULSE}});
    chk("global hiz", o_mirror_pulse_hiz, 16'h0000);
    tick(2);
    close_out();
  end
endmodule
`default_nettype wire
